/* lpfa_regs.svh */
// Register offsets, reset values and field positions of the pointer path.
`ifndef LPFA_REGS_SVH
`define LPFA_REGS_SVH

// ----------------------------------------------------------------------------
// Byte offsets on the register bus
// ----------------------------------------------------------------------------
`define LPFA_OFF_PTR_HIGH   8'h00
`define LPFA_OFF_PTR_MID    8'h04
`define LPFA_OFF_PTR_LOW    8'h08
`define LPFA_OFF_WORD_INC   8'h0c
`define LPFA_OFF_BYTE_INC   8'h10
`define LPFA_OFF_LIN_BYTE   8'h14
`define LPFA_OFF_PTR_ADD    8'h18
`define LPFA_OFF_NONE       8'hff

// ----------------------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------------------
`define LPFA_PTR_W          17
`define LPFA_PTR_TOP_BIT    16
`define LPFA_PTR_RST        17'h00000
`define LPFA_RDATA_RST      32'h00000000
`define LPFA_BYTE_HI_MSB    15
`define LPFA_BYTE_HI_LSB    8

`endif

/* lpfa_pkg.sv */
// Types shared by the linear pointer flash access path.
package lpfa_pkg;

  // --------------------------------------------------------------------------
  // Sequencer states, Gray coded along idle, data phase, bytes, done
  // --------------------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_DPH  = 3'h1,
    ST_MEM1 = 3'h3,
    ST_MEM2 = 3'h2,
    ST_DONE = 3'h6
  } lpfa_state_t;

  // --------------------------------------------------------------------------
  // Complete state of the access path
  // --------------------------------------------------------------------------
  typedef struct packed {
    lpfa_state_t st;
    logic [7:0]  off;
    logic        wr;
    logic [16:0] ptr;
    logic [15:0] wbuf;
    logic [31:0] rdata;
    logic        memReq;
    logic        memWe;
    logic [7:0]  memWdata;
  } lpfa_regs_t;

endpackage : lpfa_pkg

/* lpfa_access.sv */
// AHB-Lite slave reaching flash bytes through a linear pointer.
`timescale 1ns/10ps
`include "lpfa_regs.svh"

module lpfa_access
  import lpfa_pkg::*;
#(
  parameter int ADDR_W = 12
) (
  // Clock and reset
  input  wire logic              clk_sys,
  input  wire logic              rst,
  // AHB-Lite slave
  input  wire logic              hsel,
  input  wire logic [ADDR_W-1:0] haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic [31:0]       hwdata,
  input  wire logic              hready,
  output logic                   hreadyout,
  output logic                   hresp,
  output logic [31:0]            hrdata,
  // Flash byte access
  output logic                   memReq,
  output logic                   memWe,
  output logic [16:0]            memAddr,
  output logic [7:0]             memWdata,
  input  wire logic [7:0]        memRdata,
  input  wire logic              memAck
);

  // --------------------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------------------
  function automatic logic [16:0] ptrAdd(input logic [16:0] p,
                                         input logic [7:0]  v);
    ptrAdd = p + {{9{v[7]}}, v};
  endfunction : ptrAdd

  function automatic logic isPort(input logic [7:0] o);
    isPort = (o == `LPFA_OFF_WORD_INC) || (o == `LPFA_OFF_BYTE_INC) ||
             (o == `LPFA_OFF_LIN_BYTE);
  endfunction : isPort

  function automatic logic [31:0] readReg(input logic [7:0]  o,
                                          input logic [16:0] p);
    unique case (o)
      `LPFA_OFF_PTR_HIGH: readReg = {31'h0, p[`LPFA_PTR_TOP_BIT]};
      `LPFA_OFF_PTR_MID:  readReg = {24'h0, p[15:8]};
      `LPFA_OFF_PTR_LOW:  readReg = {24'h0, p[7:0]};
      default:            readReg = 32'h0;
    endcase
  endfunction : readReg

  lpfa_regs_t s_q;
  lpfa_regs_t s_d;
  logic       accept;
  logic       postInc;
  logic       isWord;
  logic [7:0] offIn;

  assign accept  = hsel & htrans[1] & hready;
  assign isWord  = (s_q.off == `LPFA_OFF_WORD_INC);
  assign postInc = isWord || (s_q.off == `LPFA_OFF_BYTE_INC);
  assign offIn   = (haddr[ADDR_W-1:8] == '0) ? haddr[7:0] : `LPFA_OFF_NONE;

  assign hreadyout = !((s_q.st == ST_MEM1) || (s_q.st == ST_MEM2) ||
                       ((s_q.st == ST_DPH) && isPort(s_q.off)));
  assign hresp    = 1'b0;
  assign hrdata   = s_q.rdata;
  assign memReq   = s_q.memReq;
  assign memWe    = s_q.memWe;
  assign memAddr  = s_q.ptr;
  assign memWdata = s_q.memWdata;

  // --------------------------------------------------------------------------
  // Sequencer
  // --------------------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    unique case (s_q.st)
      ST_IDLE: begin
      end
      ST_DPH: begin
        if (isPort(s_q.off)) begin
          s_d.memReq   = 1'b1;
          s_d.memWe    = s_q.wr;
          s_d.wbuf     = hwdata[15:0];
          s_d.memWdata = isWord ? hwdata[15:8] : hwdata[7:0];
          s_d.st       = ST_MEM1;
        end else if (s_q.wr) begin
          unique case (s_q.off)
            `LPFA_OFF_PTR_HIGH: s_d.ptr[`LPFA_PTR_TOP_BIT] = hwdata[0];
            `LPFA_OFF_PTR_MID:  s_d.ptr[15:8] = hwdata[7:0];
            `LPFA_OFF_PTR_LOW:  s_d.ptr[7:0]  = hwdata[7:0];
            `LPFA_OFF_PTR_ADD:  s_d.ptr = ptrAdd(s_q.ptr, hwdata[7:0]);
            default: begin
            end
          endcase
        end
      end
      ST_MEM1: begin
        if (memAck) begin
          s_d.memReq = 1'b0;
          if (!s_q.wr) begin
            s_d.rdata = isWord ? {16'h0, memRdata, 8'h0}
                               : {24'h0, memRdata};
          end else begin
            s_d.rdata = `LPFA_RDATA_RST;
          end
          if (postInc) begin
            s_d.ptr = ptrAdd(s_q.ptr, 8'h01);
          end
          if (isWord) begin
            s_d.memReq   = 1'b1;
            s_d.memWdata = s_q.wbuf[7:0];
            s_d.st       = ST_MEM2;
          end else begin
            s_d.st = ST_DONE;
          end
        end
      end
      ST_MEM2: begin
        if (memAck) begin
          s_d.memReq = 1'b0;
          if (!s_q.wr) begin
            s_d.rdata[7:0] = memRdata;
          end
          s_d.ptr = ptrAdd(s_q.ptr, 8'h01);
          s_d.st  = ST_DONE;
        end
      end
      ST_DONE: begin
      end
      default: begin
        s_d.st = ST_IDLE;
      end
    endcase
    if (hreadyout) begin
      if (accept) begin
        s_d.st    = ST_DPH;
        s_d.off   = offIn;
        s_d.wr    = hwrite;
        s_d.rdata = hwrite ? `LPFA_RDATA_RST : readReg(offIn, s_d.ptr);
      end else begin
        s_d.st = ST_IDLE;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      s_q          <= '0;
      s_q.st       <= ST_IDLE;
      s_q.ptr      <= `LPFA_PTR_RST;
      s_q.rdata    <= `LPFA_RDATA_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // --------------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------------
  a_req_uses_ptr: assert property (
    @(posedge clk_sys) disable iff (rst)
    (s_q.st == ST_DPH && isPort(s_q.off)) |=>
      memReq && memAddr == $past(s_q.ptr))
    else $error("Flash access does not start at the pointer.");

  a_inc_after_ack: assert property (
    @(posedge clk_sys) disable iff (rst)
    (s_q.st == ST_MEM1 && memAck && postInc) |=>
      memAddr == 17'($past(memAddr) + 17'h1))
    else $error("Pointer not advanced after post-increment access.");

  a_ports_same_first: assert property (
    @(posedge clk_sys) disable iff (rst)
    (s_q.st == ST_MEM1 && memAck && !memWe && postInc) |=>
      (isWord ? hrdata[15:8] : hrdata[7:0]) == $past(memRdata))
    else $error("Post-increment read returned the wrong byte.");

  a_word_two_bytes: assert property (
    @(posedge clk_sys) disable iff (rst)
    (s_q.st == ST_MEM1 && memAck && isWord) |=> memReq && !hreadyout)
    else $error("Word access did not start its second byte.");

  a_plain_read: assert property (
    @(posedge clk_sys) disable iff (rst)
    (s_q.st == ST_MEM1 && memAck && !memWe &&
     s_q.off == `LPFA_OFF_LIN_BYTE) |=> hrdata == {24'h0, $past(memRdata)})
    else $error("Plain byte read returned the wrong data.");

  a_add_signed: assert property (
    @(posedge clk_sys) disable iff (rst)
    (s_q.st == ST_DPH && s_q.wr && s_q.off == `LPFA_OFF_PTR_ADD) |=>
      memAddr == 17'($past(memAddr) + {{9{$past(hwdata[7])}},
                                        $past(hwdata[7:0])}))
    else $error("Add port did not add the signed byte.");

  a_add_minus_one: assert property (
    @(posedge clk_sys) disable iff (rst)
    (s_q.st == ST_DPH && s_q.wr && s_q.off == `LPFA_OFF_PTR_ADD &&
     hwdata[7:0] == 8'hff) |=> memAddr == 17'($past(memAddr) - 17'h1))
    else $error("Add of 0xff did not subtract one.");

  a_add_minus_128: assert property (
    @(posedge clk_sys) disable iff (rst)
    (s_q.st == ST_DPH && s_q.wr && s_q.off == `LPFA_OFF_PTR_ADD &&
     hwdata[7:0] == 8'h80) |=> memAddr == 17'($past(memAddr) - 17'h80))
    else $error("Add of 0x80 did not subtract 128.");

  a_plain_keeps_ptr: assert property (
    @(posedge clk_sys) disable iff (rst)
    (s_q.st == ST_MEM1 && memAck && s_q.off == `LPFA_OFF_LIN_BYTE) |=>
      $stable(memAddr) ##1 $stable(memAddr))
    else $error("Plain byte access moved the pointer.");

  a_ptr_wraps: assert property (
    @(posedge clk_sys) disable iff (rst)
    (s_q.st == ST_MEM1 && memAck && postInc && memAddr == 17'h1ffff) |=>
      memAddr == 17'h00000)
    else $error("Pointer did not wrap to zero.");

  a_low_byte_load: assert property (
    @(posedge clk_sys) disable iff (rst)
    (s_q.st == ST_DPH && s_q.wr && s_q.off == `LPFA_OFF_PTR_LOW) |=>
      memAddr[7:0] == $past(hwdata[7:0]) &&
      memAddr[16:8] == $past(memAddr[16:8]))
    else $error("Pointer low byte write failed.");

endmodule : lpfa_access

/* lpfa_flash_model.sv */
// Behavioural flash byte store that answers the access path's byte requests.
`timescale 1ns/10ps

module lpfa_flash_model (
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst,
  // Byte requests
  input  wire logic        memReq,
  input  wire logic        memWe,
  input  wire logic [16:0] memAddr,
  input  wire logic [7:0]  memWdata,
  output logic      [7:0]  memRdata,
  output logic             memAck,
  // Cycles to wait before each answer
  input  wire logic [1:0]  waitCycles
);
  logic [7:0] mem [0:131071];
  logic [1:0] cnt;

  // Read data is valid only beside memAck; otherwise it toggles, and reset holds it at 8'h5a.
  always @(posedge clk_sys) begin
    memAck   <= 1'b0;
    memRdata <= rst ? 8'h5a : ~memRdata;
    if (rst || !memReq || memAck) begin
      cnt <= 2'h0;
    end else if (cnt >= waitCycles) begin
      memAck   <= 1'b1;
      memRdata <= mem[memAddr];
      if (memWe) begin
        mem[memAddr] <= memWdata;
      end
    end else begin
      cnt <= cnt + 2'h1;
    end
  end
endmodule : lpfa_flash_model

/* lpfa_tb.sv */
// Self-checking bench for the linear pointer flash access path.
`timescale 1ns/10ps
`include "lpfa_regs.svh"

module tb;
  logic        clk_sys, rst, hsel, hwrite, hreadyout, hresp, hrdyN;
  logic        memReq, memWe, memAck;
  logic [11:0] haddr;
  logic [1:0]  htrans, flashWait;
  logic [2:0]  hsize;
  logic [31:0] hwdata, hrdata, rd, hrdataN;
  logic [16:0] memAddr, p, e;
  logic [7:0]  memWdata, memRdata;
  logic [7:0]  addTab [4] = '{8'hff, 8'h80, 8'h7f, 8'h01};
  int          mismatches, cmp_count, cycles;

  lpfa_access #(.ADDR_W(12)) dut_u (
    .clk_sys(clk_sys), .rst(rst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .memReq(memReq), .memWe(memWe), .memAddr(memAddr),
    .memWdata(memWdata), .memRdata(memRdata), .memAck(memAck));

  lpfa_flash_model flash_u (
    .clk_sys(clk_sys), .rst(rst), .memReq(memReq), .memWe(memWe),
    .memAddr(memAddr), .memWdata(memWdata), .memRdata(memRdata),
    .memAck(memAck), .waitCycles(flashWait));

  // ---------------------------------------------------------------------
  // Clock, initial values and hang guard
  // ---------------------------------------------------------------------
  initial begin
    clk_sys = 1'b0;
    rst = 1'b1;
    hsel = 1'b0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    haddr = 12'h000;
    hwdata = 32'h00000000;
    flashWait = 2'h0;
    forever #5 clk_sys = ~clk_sys;
  end

  // Bus outputs as they will stand at the next rising edge; reading them
  // right at that edge would race with the design's own update.
  always @(negedge clk_sys) begin
    hrdyN   <= hreadyout;
    hrdataN <= hrdata;
  end

  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 5000) begin
      mismatches++;
      end_of_test();
    end
  end

  // ---------------------------------------------------------------------
  // Bus and comparison tasks
  // ---------------------------------------------------------------------
  task automatic check(input string what, input logic [31:0] seen, exp);
    cmp_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr  <= {4'h0, a};
    do @(posedge clk_sys); while (hrdyN !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clk_sys); while (hrdyN !== 1'b1);
    rd = hrdataN;
    check("hresp", {31'h0, hresp}, 32'h0);
  endtask : ahb

  task automatic setPtr(input logic [16:0] v);
    ahb(1'b1, `LPFA_OFF_PTR_HIGH, {31'h0, v[16]});
    ahb(1'b1, `LPFA_OFF_PTR_MID, {24'h0, v[15:8]});
    ahb(1'b1, `LPFA_OFF_PTR_LOW, {24'h0, v[7:0]});
  endtask : setPtr

  task automatic chkPtr(input logic [16:0] v);
    ahb(1'b0, `LPFA_OFF_PTR_HIGH, 32'h0);
    p[16] = rd[0];
    ahb(1'b0, `LPFA_OFF_PTR_MID, 32'h0);
    p[15:8] = rd[7:0];
    ahb(1'b0, `LPFA_OFF_PTR_LOW, 32'h0);
    p[7:0] = rd[7:0];
    check("pointer", {15'h0, p}, {15'h0, v});
  endtask : chkPtr

  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : end_of_test

  // ---------------------------------------------------------------------
  // Tests
  // ---------------------------------------------------------------------
  initial begin
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    chkPtr(17'h00000);
    setPtr(17'h1fffe);
    chkPtr(17'h1fffe);
    $display("test pointer_registers done");
    ahb(1'b1, `LPFA_OFF_BYTE_INC, 32'h000000a1);
    chkPtr(17'h1ffff);
    flashWait <= 2'h3;
    ahb(1'b1, `LPFA_OFF_BYTE_INC, 32'h000000a2);
    chkPtr(17'h00000);
    setPtr(17'h1fffe);
    ahb(1'b0, `LPFA_OFF_LIN_BYTE, 32'h0);
    check("plain read", rd, 32'h000000a1);
    ahb(1'b1, `LPFA_OFF_LIN_BYTE, 32'h0000005d);
    chkPtr(17'h1fffe);
    ahb(1'b0, `LPFA_OFF_BYTE_INC, 32'h0);
    check("incr read", rd, 32'h0000005d);
    ahb(1'b0, `LPFA_OFF_BYTE_INC, 32'h0);
    check("incr read", rd, 32'h000000a2);
    chkPtr(17'h00000);
    $display("test byte_ports done");
    setPtr(17'h1ffff);
    ahb(1'b1, `LPFA_OFF_WORD_INC, 32'h0000b3c4);
    chkPtr(17'h00001);
    flashWait <= 2'h0;
    setPtr(17'h1ffff);
    ahb(1'b0, `LPFA_OFF_WORD_INC, 32'h0);
    check("word read", rd, 32'h0000b3c4);
    $display("test word_port done");
    e = 17'h00000;
    setPtr(e);
    foreach (addTab[i]) begin
      e = e + {{9{addTab[i][7]}}, addTab[i]};
      ahb(1'b1, `LPFA_OFF_PTR_ADD, {24'h0, addTab[i]});
      chkPtr(e);
    end
    ahb(1'b0, `LPFA_OFF_PTR_ADD, 32'h0);
    check("add read", rd, 32'h0);
    $display("test pointer_add done");
    ahb(1'b1, 8'h1c, 32'hffffffff);
    ahb(1'b0, 8'h1c, 32'h0);
    check("unmapped", rd, 32'h0);
    chkPtr(e);
    $display("test unmapped done");
    end_of_test();
  end
endmodule : tb
